// ==== logic/uibd_params.svh ====
// Offsets, field positions, reset values and sizes of the IN endpoint block
`ifndef UIBD_PARAMS_SVH
`define UIBD_PARAMS_SVH
`define UIBD_OFF_Y_BASE 8'h00
`define UIBD_OFF_X_COUNT 8'h04
`define UIBD_OFF_BUF_SIZE 8'h08
`define UIBD_OFF_CONFIG 8'h0c
`define UIBD_OFF_STATUS 8'h10
`define UIBD_OFF_DATA 8'h14
`define UIBD_NACK_BIT 7
`define UIBD_CNT_MSB 6
`define UIBD_CFG_ISO_BIT 0
`define UIBD_CFG_BPS_LSB 1
`define UIBD_CFG_BPS_MSB 2
`define UIBD_RST_Y_BASE 8'h00
`define UIBD_RST_X_COUNT 8'h00
`define UIBD_RST_BUF_SIZE 8'h00
`define UIBD_RST_CONFIG 3'h0
`define UIBD_ADDR_LSBS 3'h0
`define UIBD_SIZE_UNIT_LSBS 3'h0
`define UIBD_FIFO_WIDTH 8
`define UIBD_FIFO_DEPTH 8
`endif

// ==== logic/uibd_pkg.sv ====
// Types shared by the IN endpoint descriptor block
`default_nettype none
package uibd_pkg;
    typedef enum {BM_IDLE, BM_SEND, BM_WAIT} uibd_bm_state_t;
    typedef enum {SEL_NONE, SEL_Y, SEL_X, SEL_SIZE, SEL_CFG, SEL_STAT,
        SEL_DATA} uibd_sel_t;
endpackage
`default_nettype wire

// ==== logic/uibd_fifo.sv ====
// Packet data FIFO between the register bus and the transmit stream
`timescale 1ns/1ps
`default_nettype none
module uibd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [LW-1:0] next_level;
    logic push;
    logic pop;

    // Honest full and empty straight from the fill level
    assign in_ready = (level != LW'(DEPTH));
    assign out_valid = (level != '0);
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Pointers wrap at DEPTH so any depth works, not only powers of two
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
        end
        next_level = level + LW'(push) - LW'(pop);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level <= next_level;
        end
    end

    // Storage has no reset; only entries below the level are ever read
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    fifo_no_overflow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        level <= LW'(DEPTH))
        else $error("fifo level went beyond its depth");
endmodule
`default_nettype wire

// ==== logic/uibd_top.sv ====
// IN endpoint descriptor registers with buffer manager and AHB-Lite slave
//
// Notes on behaviour
// - Y base byte stores eight bits
// - Buffer address is base with three zeros
// - Count byte: flag bit 7, length 6:0
// - Successful IN transfer sets the flag
// - Flag set on non-iso endpoint answers NAK
// - Isochronous endpoints never NAK, ignore flag
// - Iso samples become bytes via sample size
// - One size byte for both buffers
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "uibd_params.svh"
module uibd_top #(
    parameter int FIFO_WIDTH = `UIBD_FIFO_WIDTH,
    parameter int FIFO_DEPTH = `UIBD_FIFO_DEPTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic in_token,
    input wire logic in_ack,
    output logic reply_nak,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [FIFO_WIDTH-1:0] tx_data,
    output logic tx_last,
    output logic [10:0] y_buf_addr,
    output logic [10:0] buf_len_bytes
);
    localparam int LW = $clog2(FIFO_DEPTH+1);

    // Bus address-phase capture
    logic dp_valid;
    logic dp_write;
    uibd_pkg::uibd_sel_t dp_sel;
    logic next_dp_valid;
    logic next_dp_write;
    uibd_pkg::uibd_sel_t next_dp_sel;
    logic [31:0] next_hrdata;
    logic accept;
    logic wr_commit;

    // Descriptor and control registers
    logic [7:0] in_ep_y_buffer_base;
    logic [7:0] in_ep_x_buffer_count;
    logic [7:0] in_ep_buffer_size;
    logic [2:0] ep_config;
    logic [7:0] next_y_base;
    logic [7:0] next_x_count;
    logic [7:0] next_buf_size;
    logic [2:0] next_config;
    logic [7:0] rd_byte;

    // Buffer manager
    uibd_pkg::uibd_bm_state_t bm_state;
    uibd_pkg::uibd_bm_state_t next_bm_state;
    logic [8:0] remaining;
    logic [8:0] next_remaining;
    logic next_reply_nak;
    logic nack_set;
    logic [8:0] pkt_bytes;
    logic iso_mode;
    logic [1:0] bytes_per_sample;

    // FIFO hookup
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [LW-1:0] fifo_level;

    // Shared by the read path and the write path
    function automatic uibd_pkg::uibd_sel_t decode(input logic [7:0] a);
        uibd_pkg::uibd_sel_t s;
        s = uibd_pkg::SEL_NONE;
        case (a)
            `UIBD_OFF_Y_BASE: s = uibd_pkg::SEL_Y;
            `UIBD_OFF_X_COUNT: s = uibd_pkg::SEL_X;
            `UIBD_OFF_BUF_SIZE: s = uibd_pkg::SEL_SIZE;
            `UIBD_OFF_CONFIG: s = uibd_pkg::SEL_CFG;
            `UIBD_OFF_STATUS: s = uibd_pkg::SEL_STAT;
            `UIBD_OFF_DATA: s = uibd_pkg::SEL_DATA;
            default: s = uibd_pkg::SEL_NONE;
        endcase
        return s;
    endfunction

    // Iso counts are samples; widen by the sample size, 1 to 4 bytes
    function automatic logic [8:0] to_bytes(input logic [6:0] cnt,
        input logic iso, input logic [1:0] bps);
        logic [8:0] c9;
        logic [8:0] r;
        c9 = {2'h0, cnt};
        r = c9;
        if (iso) begin
            case (bps)
                2'h0: r = c9;
                2'h1: r = {c9[7:0], 1'b0};
                2'h2: r = c9 + {c9[7:0], 1'b0};
                default: r = {c9[6:0], 2'h0};
            endcase
        end
        return r;
    endfunction

    assign iso_mode = ep_config[`UIBD_CFG_ISO_BIT];
    assign bytes_per_sample = ep_config[`UIBD_CFG_BPS_MSB:`UIBD_CFG_BPS_LSB];
    assign pkt_bytes = to_bytes(in_ep_x_buffer_count[`UIBD_CNT_MSB:0],
        iso_mode, bytes_per_sample);

    // Buffer start and length as the transmit side sees them
    assign y_buf_addr = {in_ep_y_buffer_base, `UIBD_ADDR_LSBS};
    assign buf_len_bytes = {in_ep_buffer_size, `UIBD_SIZE_UNIT_LSBS};

    // Data writes stall the bus while the FIFO is full; freeze also stalls
    assign fifo_in_valid = dp_valid && dp_write &&
        (dp_sel == uibd_pkg::SEL_DATA);
    assign hreadyout = ce && !(fifo_in_valid && !fifo_in_ready);
    assign hresp = 1'b0;
    assign accept = hsel && htrans[1] && hready;
    assign wr_commit = dp_valid && dp_write && hreadyout;

    // Address phase is held until the previous data phase completes
    always_comb begin
        next_dp_valid = dp_valid;
        next_dp_write = dp_write;
        next_dp_sel = dp_sel;
        next_hrdata = hrdata;
        if (hready) begin
            next_dp_valid = accept;
            next_dp_write = hwrite;
            next_dp_sel = decode(haddr[7:0]);
            if (accept && !hwrite) begin
                next_hrdata = {24'h0, rd_byte};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_sel <= uibd_pkg::SEL_NONE;
            hrdata <= 32'h0;
        end else if (ce) begin
            dp_valid <= next_dp_valid;
            dp_write <= next_dp_write;
            dp_sel <= next_dp_sel;
            hrdata <= next_hrdata;
        end
    end

    // Read from next values so a write just ahead is seen at once
    always_comb begin
        unique case (decode(haddr[7:0]))
            uibd_pkg::SEL_Y: rd_byte = next_y_base;
            uibd_pkg::SEL_X: rd_byte = next_x_count;
            uibd_pkg::SEL_SIZE: rd_byte = next_buf_size;
            uibd_pkg::SEL_CFG: rd_byte = {5'h0, next_config};
            uibd_pkg::SEL_STAT: rd_byte = {3'h0,
                bm_state != uibd_pkg::BM_IDLE, 4'(fifo_level)};
            uibd_pkg::SEL_DATA: rd_byte = 8'h00;
            uibd_pkg::SEL_NONE: rd_byte = 8'h00;
        endcase
    end

    // Register writes; hardware setting the flag beats a software clear
    always_comb begin
        next_y_base = in_ep_y_buffer_base;
        next_x_count = in_ep_x_buffer_count;
        next_buf_size = in_ep_buffer_size;
        next_config = ep_config;
        if (wr_commit) begin
            unique case (dp_sel)
                uibd_pkg::SEL_Y: next_y_base = hwdata[7:0];
                uibd_pkg::SEL_X: next_x_count = hwdata[7:0];
                uibd_pkg::SEL_SIZE: next_buf_size = hwdata[7:0];
                uibd_pkg::SEL_CFG: next_config = hwdata[2:0];
                uibd_pkg::SEL_STAT: next_config = ep_config;
                uibd_pkg::SEL_DATA: next_config = ep_config;
                uibd_pkg::SEL_NONE: next_config = ep_config;
            endcase
        end
        if (nack_set) begin
            next_x_count[`UIBD_NACK_BIT] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_ep_y_buffer_base <= `UIBD_RST_Y_BASE;
            in_ep_x_buffer_count <= `UIBD_RST_X_COUNT;
            in_ep_buffer_size <= `UIBD_RST_BUF_SIZE;
            ep_config <= `UIBD_RST_CONFIG;
        end else if (ce) begin
            in_ep_y_buffer_base <= next_y_base;
            in_ep_x_buffer_count <= next_x_count;
            in_ep_buffer_size <= next_buf_size;
            ep_config <= next_config;
        end
    end

    // Transmit stream drains the FIFO only while a packet is in flight
    assign tx_valid = ce && (bm_state == uibd_pkg::BM_SEND) && fifo_out_valid;
    assign fifo_out_ready = (bm_state == uibd_pkg::BM_SEND) && tx_ready;
    assign tx_last = (remaining == 9'h001);

    // Buffer manager: NAK, send, then wait for the host handshake.
    // A token while waiting means the host lost our data; the bytes are
    // gone from the FIFO, so it is refused with NAK rather than resent.
    always_comb begin
        next_bm_state = bm_state;
        next_remaining = remaining;
        next_reply_nak = 1'b0;
        nack_set = 1'b0;
        unique case (bm_state)
            uibd_pkg::BM_IDLE: begin
                if (in_token) begin
                    if (!iso_mode && in_ep_x_buffer_count[`UIBD_NACK_BIT]) begin
                        next_reply_nak = 1'b1;
                    end else if (pkt_bytes == 9'h000) begin
                        // Zero-length packet needs no data from the FIFO
                        if (iso_mode) begin
                            nack_set = 1'b1;
                        end else begin
                            next_bm_state = uibd_pkg::BM_WAIT;
                        end
                    end else begin
                        next_remaining = pkt_bytes;
                        next_bm_state = uibd_pkg::BM_SEND;
                    end
                end
            end
            uibd_pkg::BM_SEND: begin
                if (tx_valid && tx_ready) begin
                    next_remaining = remaining - 9'h001;
                    if (tx_last) begin
                        if (iso_mode) begin
                            // Iso has no handshake: done when sent
                            nack_set = 1'b1;
                            next_bm_state = uibd_pkg::BM_IDLE;
                        end else begin
                            next_bm_state = uibd_pkg::BM_WAIT;
                        end
                    end
                end
            end
            uibd_pkg::BM_WAIT: begin
                if (in_ack) begin
                    nack_set = 1'b1;
                    next_bm_state = uibd_pkg::BM_IDLE;
                end else if (in_token) begin
                    next_reply_nak = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bm_state <= uibd_pkg::BM_IDLE;
            remaining <= 9'h000;
            reply_nak <= 1'b0;
        end else if (ce) begin
            bm_state <= next_bm_state;
            remaining <= next_remaining;
            reply_nak <= next_reply_nak;
        end
    end

    // Packet bytes queue here between software writes and the wire
    uibd_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) i_uibd_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(hwdata[FIFO_WIDTH-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(tx_data),
        .level(fifo_level)
    );

    // Checks on the descriptor and buffer manager behaviour
    y_base_store_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_commit && dp_sel == uibd_pkg::SEL_Y)
        |=> y_buf_addr == {$past(hwdata[7:0]), 3'h0})
        else $error("Y base write did not reach the buffer address");

    count_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_commit && dp_sel == uibd_pkg::SEL_X && !nack_set)
        |=> in_ep_x_buffer_count == $past(hwdata[7:0]))
        else $error("count byte did not take the written value");

    nack_on_ack_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && bm_state == uibd_pkg::BM_WAIT && in_ack)
        |=> in_ep_x_buffer_count[7] && bm_state == uibd_pkg::BM_IDLE)
        else $error("flag not set after successful IN transfer");

    nak_reply_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && bm_state == uibd_pkg::BM_IDLE && in_token && !iso_mode
        && in_ep_x_buffer_count[7])
        |=> reply_nak && bm_state == uibd_pkg::BM_IDLE)
        else $error("flagged endpoint did not answer NAK");

    iso_no_nak_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && bm_state == uibd_pkg::BM_IDLE && in_token && iso_mode)
        |=> !reply_nak)
        else $error("isochronous endpoint answered NAK");

    iso_bytes_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && bm_state == uibd_pkg::BM_IDLE && in_token && iso_mode
        && bytes_per_sample == 2'h1 && in_ep_x_buffer_count[6:0] != 7'h00)
        |=> remaining == {1'b0, $past(in_ep_x_buffer_count[6:0]), 1'b0})
        else $error("sample count not doubled for two-byte samples");

    size_len_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_commit && dp_sel == uibd_pkg::SEL_SIZE)
        |=> buf_len_bytes == {$past(hwdata[7:0]), 3'h0})
        else $error("buffer length is not eight times the size byte");

    send_count_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (tx_valid && tx_ready && tx_last && !iso_mode)
        |=> bm_state == uibd_pkg::BM_WAIT && remaining == 9'h000)
        else $error("packet end did not move to the handshake wait");

    bus_stall_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && !hreadyout) |-> (fifo_in_valid && !fifo_in_ready))
        else $error("bus stalled without a full FIFO");
endmodule
`default_nettype wire

// ==== verif/uibd_host_model.sv ====
// Host side model: sends IN tokens, takes the byte stream, acknowledges
`timescale 1ns/1ps
`default_nettype none
module uibd_host_model (
    input wire logic hclk,
    output logic in_token,
    output logic in_ack,
    output logic tx_ready,
    input wire logic reply_nak,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last
);
    logic nak_s;
    logic valid_s;
    logic last_s;
    logic [7:0] data_s;
    logic [7:0] got [$];
    int last_at;

    // Strobes stand low outside a transfer
    initial begin
        in_token = 1'b0;
        in_ack = 1'b0;
        tx_ready = 1'b0;
        last_at = -1;
    end

    // Snapshot mid-cycle; block outputs only move after rising edges
    always @(negedge hclk) begin
        nak_s = reply_nak;
        valid_s = tx_valid;
        last_s = tx_last;
        data_s = tx_data;
    end

    // One IN token, then take bytes until the last one or a NAK
    task automatic in_xfer(input int stall, output int n, output logic nak);
        logic done;
        done = 1'b0;
        nak = 1'b0;
        got.delete();
        last_at = -1;
        in_token <= 1'b1;
        @(posedge hclk);
        in_token <= 1'b0;
        for (int c = 0; c < 400 && !done; c++) begin
            // A stall every few cycles keeps bytes waiting in the fifo
            tx_ready <= (stall == 0) || (c % stall != 0);
            @(posedge hclk);
            if (nak_s) begin
                nak = 1'b1;
                done = 1'b1;
            end
            if (valid_s && tx_ready) begin
                got.push_back(data_s);
                if (last_s) begin
                    last_at = got.size() - 1;
                    done = 1'b1;
                end
            end
        end
        tx_ready <= 1'b0;
        n = got.size();
    endtask

    // Host handshake for the packet just taken
    task automatic ack();
        in_ack <= 1'b1;
        @(posedge hclk);
        in_ack <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verif/uibd_top_tb_top.sv ====
// Self-checking testbench for the IN endpoint descriptor block
`timescale 1ns/1ps
`default_nettype none
`include "uibd_params.svh"
module uibd_top_tb_top;
    localparam logic [7:0] A_Y = `UIBD_OFF_Y_BASE;
    localparam logic [7:0] A_X = `UIBD_OFF_X_COUNT;
    localparam logic [7:0] A_SZ = `UIBD_OFF_BUF_SIZE;
    localparam logic [7:0] A_CF = `UIBD_OFF_CONFIG;
    localparam logic [7:0] A_ST = `UIBD_OFF_STATUS;
    localparam logic [7:0] A_D = `UIBD_OFF_DATA;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd_s;
    logic hreadyout, hresp, rdy_s, in_token, in_ack, tx_ready;
    logic reply_nak, tx_valid, tx_last;
    logic [7:0] tx_data;
    logic [10:0] y_buf_addr, buf_len_bytes;
    logic [7:0] pat [4] = '{8'hff, 8'h01, 8'ha5, 8'h18};
    int comparisons = 0;
    int miscompares = 0;
    int cycles = 0;

    uibd_top i_uibd_top (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .in_token(in_token), .in_ack(in_ack), .reply_nak(reply_nak),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .tx_last(tx_last), .y_buf_addr(y_buf_addr),
        .buf_len_bytes(buf_len_bytes));
    uibd_host_model i_host (.hclk(hclk), .in_token(in_token),
        .in_ack(in_ack), .tx_ready(tx_ready), .reply_nak(reply_nak),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));

    // 100 MHz clock; ready snapshot mid-cycle avoids edge races
    always #5 hclk = ~hclk;
    always @(negedge hclk) begin
        rdy_s = hreadyout;
        rd_s = hrdata;
    end

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single AHB-Lite transfer; each phase held until hready is seen high
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (rdy_s !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? wd : 32'h0;
        do @(posedge hclk); while (rdy_s !== 1'b1);
        rd = rd_s;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, {24'h0, d}, rd);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        chk(rd, {24'h0, exp});
    endtask

    // Byte pattern first, first+1, ... into the data fifo
    task automatic push(input int n, input logic [7:0] first);
        for (int i = 0; i < n; i++) begin
            wr(A_D, first + 8'(i));
        end
    endtask

    // Token, then compare NAK, byte count, bytes and end marker
    task automatic xfer(input int stall, input int nexp,
        input logic [7:0] first, input logic nak_exp);
        int n;
        logic nak;
        i_host.in_xfer(stall, n, nak);
        chk({31'h0, nak}, {31'h0, nak_exp});
        chk(32'(n), 32'(nexp));
        for (int i = 0; i < n && i < nexp; i++) begin
            chk({24'h0, i_host.got[i]}, {24'h0, first + 8'(i)});
        end
        chk(32'(i_host.last_at), 32'(nexp - 1));
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(A_Y, 8'h00);
        rd_chk(A_X, 8'h00);
        rd_chk(A_SZ, 8'h00);
        // Base and size bytes at boundary patterns, derived figures too
        foreach (pat[i]) begin
            wr(A_Y, pat[i]);
            wr(A_SZ, pat[i]);
            rd_chk(A_Y, pat[i]);
            rd_chk(A_SZ, pat[i]);
            chk({21'h0, y_buf_addr}, {21'h0, pat[i], 3'h0});
            chk({21'h0, buf_len_bytes}, 32'(pat[i]) * 8);
        end
        wr(A_X, 8'hff);
        rd_chk(A_X, 8'hff);
        wr(A_X, 8'h2a);
        rd_chk(A_X, 8'h2a);
        // Low clock enable holds the bus off; the write lands once it rises
        ce <= 1'b0;
        fork
            wr(A_Y, 8'h3c);
            begin
                repeat (3) @(posedge hclk);
                chk({31'h0, rdy_s}, 32'h0);
                ce <= 1'b1;
            end
        join
        rd_chk(A_Y, 8'h3c);
        chk({31'h0, hresp}, 32'h0);
        // Unmapped place and read-only status ignore writes
        wr(8'h18, 8'h5a);
        rd_chk(8'h18, 8'h00);
        wr(A_ST, 8'h5a);
        rd_chk(A_ST, 8'h00);
        // Bulk style packet: flag only after the host acknowledges
        wr(A_CF, 8'h00);
        push(3, 8'h40);
        wr(A_X, 8'h03);
        xfer(3, 3, 8'h40, 1'b0);
        rd_chk(A_X, 8'h03);
        i_host.ack();
        rd_chk(A_X, 8'h83);
        push(2, 8'h50);
        xfer(0, 0, 8'h00, 1'b1);
        wr(A_X, 8'h02);
        xfer(0, 2, 8'h50, 1'b0);
        i_host.ack();
        // Isochronous: flag left set, two samples of each size code
        for (int b = 0; b < 4; b++) begin
            wr(A_CF, {5'h0, 2'(b), 1'b1});
            push(2 * (b + 1), 8'h60 + 8'(b * 8));
            wr(A_X, (b % 2 == 1) ? 8'h82 : 8'h02);
            xfer(2, 2 * (b + 1), 8'h60 + 8'(b * 8), 1'b0);
            rd_chk(A_X, 8'h82);
        end
        // Fill the fifo until a push is held off, then drain with stalls
        wr(A_CF, 8'h00);
        wr(A_X, 8'h09);
        push(8, 8'h70);
        rd_chk(A_ST, 8'h08);
        fork
            wr(A_D, 8'h78);
            begin
                repeat (3) @(posedge hclk);
                #1;
                chk({31'h0, hreadyout}, 32'h0);
                @(posedge hclk);
                xfer(3, 9, 8'h70, 1'b0);
            end
        join
        i_host.ack();
        rd_chk(A_X, 8'h89);
        rd_chk(A_ST, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
